// ---- inc/asrt_consts.svh ----
// constants for the asynchronous serial block with rate timer
`ifndef ASRT_CONSTS_SVH
`define ASRT_CONSTS_SVH
`define ASRT_DATA_IDX 32'h0000_0023
`define ASRT_DATA_ADDR 32'h0000_008C
`define ASRT_CTRL_ADDR 32'h0000_0090
`define ASRT_DIV_ADDR 32'h0000_0094
`define ASRT_TMR_ADDR 32'h0000_0098
`define ASRT_STAT_ADDR 32'h0000_009C
`define ASRT_B_TXEN 0
`define ASRT_B_TXSEL 1
`define ASRT_B_WLEN 2
`define ASRT_B_PEN 3
`define ASRT_B_PPOL 4
`define ASRT_B_RXEN 5
`define ASRT_B_SEM 6
`define ASRT_B_ERR 7
`define ASRT_CTRL_RST 8'h00
`define ASRT_DIV_RST 16'h0000
`define ASRT_OVS 5'h10
`define ASRT_HALF 4'h7
`define ASRT_MID 4'h8
`endif

// ---- inc/asrt_pkg.sv ----
// types for the asynchronous serial block
package asrt_pkg;
    typedef enum logic [2:0] {ASRT_TX_IDLE, ASRT_TX_START, ASRT_TX_DATA, ASRT_TX_PAR, ASRT_TX_STOP} asrt_tx_e;
    typedef enum logic [2:0] {ASRT_RX_IDLE, ASRT_RX_START, ASRT_RX_DATA, ASRT_RX_PAR, ASRT_RX_STOP} asrt_rx_e;
endpackage

// ---- logic/asrt_parity.sv ----
// parity bit for a 7 or 8 bit character
`timescale 1ns/10ps
module asrt_parity
(
    // character and mode
    input wire logic [7:0] data_i,
    input wire logic eight_i,
    input wire logic even_i,
    // parity bit to send or expect
    output logic par_o
);
    logic ones;
    assign ones = ^{eight_i & data_i[7], data_i[6:0]};
    // odd: total ones odd, so bit = ~ones
    assign par_o = even_i ? ones : ~ones;
endmodule

// ---- logic/asrt_rate_timer.sv ----
// interval timer that sets the oversampling tick
`timescale 1ns/10ps
`include "asrt_consts.svh"
module asrt_rate_timer
    import asrt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // control
    input wire logic run_i,
    input wire logic interval_i,
    input wire logic reload_i,
    input wire logic [15:0] divisor_i,
    // tick out
    output logic tick_o,
    output logic [15:0] count_o
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic stopped;
    logic next_stopped;
    logic next_tick;

    always_comb begin
        next_cnt = cnt;
        next_stopped = stopped;
        next_tick = 1'b0;
        if (reload_i) begin
            next_cnt = divisor_i;
            next_stopped = 1'b0;
        end else if (run_i && (interval_i || !stopped)) begin
            if (cnt == 16'h0000) begin
                next_tick = 1'b1;
                // one-shot mode parks at zero; interval mode restarts a parked timer
                if (interval_i) begin
                    next_cnt = divisor_i;
                    next_stopped = 1'b0;
                end else begin
                    next_stopped = 1'b1;
                end
            end else begin
                next_cnt = cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cnt <= `ASRT_DIV_RST;
            stopped <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            stopped <= next_stopped;
            tick_o <= next_tick;
        end
    end

    assign count_o = cnt;
endmodule

// ---- logic/asrt_top.sv ----
// asynchronous serial transmitter/receiver with rate timer and apb registers
// Functional notes
// - each serial bit lasts sixteen timer expiries
// - any enabled direction forces the timer into interval mode
// - transmitter and receiver have independent enables
// - seven or eight data bits, optional odd or even parity
// - transmitter adds start, parity and stop bits itself
// - one stop bit with parity, two without
// - receiver needs start, data, optional parity and one stop bit
// - data address writes transmit register, reads receive register
// - transmit interrupt gated by enable; select picks byte or message end
// - receiver and its status work only while receiver enabled
// - receiver uses sixteen ticks per bit, samples near centre
// - a low lasting under half a bit is a false start
// - shared error flag on parity, framing or overrun
// - overrun when new character lands before previous one read
// - receive interrupt on each transfer into receive data register
// - seven-bit mode drops top written bit, reads top bit zero
// - parity polarity clear gives odd ones count, set gives even
// - error flag cleared by reset or writing one
// - writing transmit data clears the transmit interrupt
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "asrt_consts.svh"
module asrt_top
    import asrt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial link
    input wire logic rxd_i,
    output logic txd_o,
    // interrupt requests
    output logic tx_interrupt_o,
    output logic rx_interrupt_o
);
    logic [7:0] ctrl, next_ctrl;
    logic [15:0] divisor, next_divisor;
    logic tmr_interval, next_tmr_interval;
    logic [7:0] tx_data, next_tx_data;
    logic tx_full, next_tx_full;
    logic [7:0] rx_data, next_rx_data;
    logic rx_full, next_rx_full;
    logic rx_irq, next_rx_irq;
    logic tx_irq_clr, next_tx_irq_clr;
    logic [31:0] rdata, next_rdata;
    asrt_tx_e tx_st, next_tx_st;
    logic [3:0] tx_sub, next_tx_sub;
    logic [2:0] tx_bit, next_tx_bit;
    logic [1:0] tx_stops, next_tx_stops;
    logic [7:0] tx_shift, next_tx_shift;
    logic tx_par, next_tx_par;
    logic txd, next_txd;
    asrt_rx_e rx_st, next_rx_st;
    logic [3:0] rx_sub, next_rx_sub;
    logic [2:0] rx_bit, next_rx_bit;
    logic [7:0] rx_shift, next_rx_shift;

    logic tick, wr, rd, txen, rxen, eight, pen, ppol, tx_par_calc, rx_par_calc, div_wr, xfer, par_err, next_par_err;
    logic [15:0] tmr_count;
    logic [2:0] last_bit;

    assign wr = psel_i & penable_i & pwrite_i;
    assign rd = psel_i & penable_i & ~pwrite_i;
    assign txen = ctrl[`ASRT_B_TXEN];
    assign rxen = ctrl[`ASRT_B_RXEN];
    assign eight = ctrl[`ASRT_B_WLEN];
    assign pen = ctrl[`ASRT_B_PEN];
    assign ppol = ctrl[`ASRT_B_PPOL];
    assign last_bit = eight ? 3'd7 : 3'd6;
    assign div_wr = wr && paddr_i == `ASRT_DIV_ADDR;

    asrt_rate_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .run_i(1'b1),
        .interval_i(tmr_interval | txen | rxen),
        .reload_i(div_wr),
        .divisor_i(div_wr ? pwdata_i[15:0] : divisor),
        .tick_o(tick),
        .count_o(tmr_count)
    );

    asrt_parity u_tx_par (
        .data_i(tx_data),
        .eight_i(eight),
        .even_i(ppol),
        .par_o(tx_par_calc)
    );

    asrt_parity u_rx_par (
        .data_i(rx_shift),
        .eight_i(eight),
        .even_i(ppol),
        .par_o(rx_par_calc)
    );

    // register file and apb
    always_comb begin
        next_ctrl = ctrl;
        next_divisor = divisor;
        next_tmr_interval = tmr_interval;
        next_tx_data = tx_data;
        next_tx_full = tx_full;
        next_tx_irq_clr = tx_irq_clr;
        next_rdata = rdata;
        if (wr) begin
            unique case (paddr_i)
                `ASRT_DATA_ADDR: begin
                    next_tx_data = {eight & pwdata_i[7], pwdata_i[6:0]};
                    next_tx_full = 1'b1;
                    next_tx_irq_clr = 1'b1;
                end
                `ASRT_CTRL_ADDR: begin
                    next_ctrl[6:0] = pwdata_i[6:0];
                    // clearing tx enable also clears the source select
                    next_ctrl[`ASRT_B_TXSEL] = pwdata_i[`ASRT_B_TXSEL] & pwdata_i[`ASRT_B_TXEN];
                    if (pwdata_i[`ASRT_B_ERR]) begin
                        next_ctrl[`ASRT_B_ERR] = 1'b0;
                    end
                end
                `ASRT_DIV_ADDR: next_divisor = pwdata_i[15:0];
                `ASRT_TMR_ADDR: next_tmr_interval = pwdata_i[0];
                default: ;
            endcase
        end
        // captured in the setup cycle so the word stands at the access edge
        if (psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
                `ASRT_DATA_ADDR: next_rdata = {24'h00_0000, eight & next_rx_data[7], next_rx_data[6:0]};
                `ASRT_CTRL_ADDR: next_rdata = {24'h00_0000, ctrl};
                `ASRT_DIV_ADDR: next_rdata = {16'h0000, divisor};
                `ASRT_TMR_ADDR: next_rdata = {31'h0000_0000, tmr_interval};
                `ASRT_STAT_ADDR: next_rdata = {16'h0000, tmr_count};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        if (tx_st == ASRT_TX_IDLE && tx_full && txen && tick) begin
            next_tx_full = wr && paddr_i == `ASRT_DATA_ADDR;
            next_tx_irq_clr = 1'b0;
        end
        if (xfer && (rx_full || !rxd_i || (pen && par_err))) begin
            next_ctrl[`ASRT_B_ERR] = 1'b1;
        end
    end

    // transmitter
    always_comb begin
        next_tx_st = tx_st;
        next_tx_sub = tx_sub;
        next_tx_bit = tx_bit;
        next_tx_stops = tx_stops;
        next_tx_shift = tx_shift;
        next_tx_par = tx_par;
        next_txd = 1'b1;
        if (!txen) begin
            next_tx_st = ASRT_TX_IDLE;
        end else if (tick) begin
            next_tx_sub = tx_sub + 4'h1;
            unique case (tx_st)
                ASRT_TX_IDLE: begin
                    if (tx_full) begin
                        next_tx_st = ASRT_TX_START;
                        next_tx_shift = tx_data;
                        next_tx_par = tx_par_calc;
                        next_tx_sub = 4'h0;
                    end
                end
                ASRT_TX_START: if (tx_sub == 4'hF) begin
                    next_tx_st = ASRT_TX_DATA;
                    next_tx_bit = 3'd0;
                end
                ASRT_TX_DATA: if (tx_sub == 4'hF) begin
                    next_tx_shift = {1'b0, tx_shift[7:1]};
                    next_tx_bit = tx_bit + 3'd1;
                    if (tx_bit == last_bit) begin
                        next_tx_st = pen ? ASRT_TX_PAR : ASRT_TX_STOP;
                        next_tx_stops = pen ? 2'd1 : 2'd2;
                    end
                end
                ASRT_TX_PAR: if (tx_sub == 4'hF) begin
                    next_tx_st = ASRT_TX_STOP;
                end
                ASRT_TX_STOP: if (tx_sub == 4'hF) begin
                    next_tx_stops = tx_stops - 2'd1;
                    if (tx_stops == 2'd1) begin
                        next_tx_st = ASRT_TX_IDLE;
                    end
                end
            endcase
        end
        unique case (next_tx_st)
            ASRT_TX_START: next_txd = 1'b0;
            ASRT_TX_DATA: next_txd = next_tx_shift[0];
            ASRT_TX_PAR: next_txd = next_tx_par;
            default: next_txd = 1'b1;
        endcase
    end

    // receiver
    logic rx_par_bad;
    assign rx_par_bad = rxd_i != rx_par_calc;
    always_comb begin
        next_rx_st = rx_st;
        next_rx_sub = rx_sub;
        next_rx_bit = rx_bit;
        next_rx_shift = rx_shift;
        next_rx_data = rx_data;
        next_rx_full = rx_full;
        next_rx_irq = rx_irq;
        xfer = 1'b0;
        if (rd && paddr_i == `ASRT_DATA_ADDR) begin
            next_rx_full = 1'b0;
            next_rx_irq = 1'b0;
        end
        if (!rxen) begin
            next_rx_st = ASRT_RX_IDLE;
            next_rx_data[7] = 1'b0;
            next_rx_irq = 1'b0;
        end else if (tick) begin
            next_rx_sub = rx_sub + 4'h1;
            unique case (rx_st)
                ASRT_RX_IDLE: if (!rxd_i) begin
                    next_rx_st = ASRT_RX_START;
                    next_rx_sub = 4'h0;
                end
                ASRT_RX_START: begin
                    if (rxd_i) begin
                        next_rx_st = ASRT_RX_IDLE;
                    end else if (rx_sub == `ASRT_HALF) begin
                        next_rx_st = ASRT_RX_DATA;
                        next_rx_sub = 4'h0;
                        next_rx_bit = 3'd0;
                        next_rx_shift = 8'h00;
                    end
                end
                ASRT_RX_DATA: if (rx_sub == 4'hF) begin
                    next_rx_shift[rx_bit] = rxd_i;
                    next_rx_bit = rx_bit + 3'd1;
                    if (rx_bit == last_bit) begin
                        next_rx_st = pen ? ASRT_RX_PAR : ASRT_RX_STOP;
                    end
                end
                ASRT_RX_PAR: if (rx_sub == 4'hF) begin
                    next_rx_st = ASRT_RX_STOP;
                end
                ASRT_RX_STOP: if (rx_sub == 4'hF) begin
                    next_rx_st = ASRT_RX_IDLE;
                    xfer = 1'b1;
                    next_rx_data = rx_shift;
                    next_rx_full = 1'b1;
                    next_rx_irq = 1'b1;
                end
            endcase
        end
    end

    // parity result held across the stop bit
    always_comb begin
        next_par_err = par_err;
        if (tick && rx_st == ASRT_RX_PAR && rx_sub == 4'hF) begin
            next_par_err = rx_par_bad;
        end else if (rx_st == ASRT_RX_START) begin
            next_par_err = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctrl <= `ASRT_CTRL_RST;
            divisor <= `ASRT_DIV_RST;
            tmr_interval <= 1'b0;
            tx_data <= 8'h00;
            tx_full <= 1'b0;
            tx_irq_clr <= 1'b1;
            rdata <= 32'h0000_0000;
            rx_data <= 8'h00;
            rx_full <= 1'b0;
            rx_irq <= 1'b0;
            par_err <= 1'b0;
            tx_st <= ASRT_TX_IDLE;
            tx_sub <= 4'h0;
            tx_bit <= 3'd0;
            tx_stops <= 2'd0;
            tx_shift <= 8'h00;
            tx_par <= 1'b0;
            txd <= 1'b1;
            rx_st <= ASRT_RX_IDLE;
            rx_sub <= 4'h0;
            rx_bit <= 3'd0;
            rx_shift <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            divisor <= next_divisor;
            tmr_interval <= next_tmr_interval;
            tx_data <= next_tx_data;
            tx_full <= next_tx_full;
            tx_irq_clr <= next_tx_irq_clr;
            rdata <= next_rdata;
            rx_data <= next_rx_data;
            rx_full <= next_rx_full;
            rx_irq <= next_rx_irq;
            par_err <= next_par_err;
            tx_st <= next_tx_st;
            tx_sub <= next_tx_sub;
            tx_bit <= next_tx_bit;
            tx_stops <= next_tx_stops;
            tx_shift <= next_tx_shift;
            tx_par <= next_tx_par;
            txd <= next_txd;
            rx_st <= next_rx_st;
            rx_sub <= next_rx_sub;
            rx_bit <= next_rx_bit;
            rx_shift <= next_rx_shift;
        end
    end

    assign txd_o = txd;
    assign prdata_o = rdata;
    assign pready_o = psel_i & penable_i;
    assign pslverr_o = 1'b0;
    // tx_irq_clr low means a pending empty event not yet cleared by a write
    assign tx_interrupt_o = txen & ~tx_irq_clr & ~tx_full
        & (~ctrl[`ASRT_B_TXSEL] | tx_st == ASRT_TX_IDLE);
    assign rx_interrupt_o = rx_irq & rxen;
endmodule

// ---- verif/asrt_station.sv ----
// remote serial station model facing the block's serial pins
`timescale 1ns/10ps
module asrt_station
(
    // clock
    input wire logic clk_sys_i,
    // serial lines
    input wire logic txd_i,
    output logic rxd_o
);
    int bit_clks = 32;
    int nbits = 8;
    logic pen = 1'b0;
    logic even = 1'b0;
    logic [7:0] rx_data;
    logic frame_ok;
    int rx_cnt = 0;
    int cyc = 0;
    int last_start = 0;
    int gap = 0;
    initial rxd_o = 1'b1;
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    function automatic logic par_of(input logic [7:0] d, input int n, input logic ev);
        logic p;
        p = ^(n == 7 ? {1'b0, d[6:0]} : d);
        return ev ? p : ~p;
    endfunction
    // samples mid-bit, one stop bit only
    always begin
        @(negedge txd_i);
        gap = cyc - last_start;
        last_start = cyc;
        repeat (bit_clks / 2) @(posedge clk_sys_i);
        rx_data = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge clk_sys_i);
            rx_data[i] = txd_i;
        end
        frame_ok = 1'b1;
        if (pen) begin
            repeat (bit_clks) @(posedge clk_sys_i);
            frame_ok = txd_i === par_of(rx_data, nbits, even);
        end
        repeat (bit_clks) @(posedge clk_sys_i);
        frame_ok = frame_ok && txd_i === 1'b1;
        rx_cnt++;
    end
    task automatic drive(input logic b, input int n);
        rxd_o <= b;
        repeat (n) @(posedge clk_sys_i);
    endtask
    // one stop bit is all the receiver may rely on
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        drive(1'b0, bit_clks);
        for (int i = 0; i < nbits; i++) drive(d[i], bit_clks);
        if (pen) drive(par_of(d, nbits, even) ^ bad_par, bit_clks);
        drive(~bad_stop, bit_clks);
        drive(1'b1, bit_clks);
    endtask
endmodule

// ---- verif/asrt_top_properties.sv ----
// port checker for the serial block, bound to its top
`timescale 1ns/10ps
`include "asrt_consts.svh"
module asrt_top_properties
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    // serial and interrupts
    input wire logic txd_o,
    input wire logic tx_interrupt_o,
    input wire logic rx_interrupt_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic acc;
    logic rd_setup;
    logic [15:0] div;
    logic tx_en;
    logic rx_en;
    logic tx_ever;
    int low_run;
    assign acc = psel_i && penable_i;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    // shadow of the control fields that gate the outputs
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            div <= 16'h0000;
            tx_en <= 1'b0;
            rx_en <= 1'b0;
            tx_ever <= 1'b0;
            low_run <= 0;
        end else begin
            if (acc && pwrite_i && paddr_i == `ASRT_DIV_ADDR) begin
                div <= pwdata_i[15:0];
            end
            if (acc && pwrite_i && paddr_i == `ASRT_CTRL_ADDR) begin
                tx_en <= pwdata_i[0];
                rx_en <= pwdata_i[5];
            end
            tx_ever <= tx_ever || tx_en;
            low_run <= txd_o ? 0 : low_run + 1;
        end
    end
    sequence s_wr(a);
        acc && pwrite_i && paddr_i == a;
    endsequence
    sequence s_rd(a);
        acc && !pwrite_i && paddr_i == a;
    endsequence
    property p_ready;
        psel_i |-> pready_o == penable_i;
    endproperty
    property p_prdata_hold;
        !$past(rd_setup) |-> $stable(prdata_o);
    endproperty
    property p_unmapped;
        s_rd(32'h0000_00F0) |-> prdata_o == 32'h0000_0000;
    endproperty
    property p_reset_quiet;
        disable iff (1'b0) !resetn_i |=> txd_o && !tx_interrupt_o && !rx_interrupt_o;
    endproperty
    // every low stretch on the line is a whole number of bits
    property p_bit_len;
        $rose(txd_o) |-> (low_run % (16 * (int'(div) + 1))) == 0;
    endproperty
    property p_tx_gate;
        !tx_en |-> !tx_interrupt_o;
    endproperty
    property p_tx_clear;
        s_wr(`ASRT_DATA_ADDR) |=> !tx_interrupt_o;
    endproperty
    property p_rx_gate;
        !rx_en |-> !rx_interrupt_o;
    endproperty
    property p_tx_idle;
        !tx_ever |-> txd_o;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not in access cycle");
    a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy in reset");
    a_bit_len: assert property (p_bit_len) else $error("bit length off");
    a_tx_gate: assert property (p_tx_gate) else $error("tx irq while disabled");
    a_tx_clear: assert property (p_tx_clear) else $error("tx irq after data write");
    a_rx_gate: assert property (p_rx_gate) else $error("rx irq while disabled");
    a_tx_idle: assert property (p_tx_idle) else $error("line not idle high");
endmodule
bind asrt_top asrt_top_properties asrt_top_properties_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .txd_o(txd_o), .tx_interrupt_o(tx_interrupt_o),
    .rx_interrupt_o(rx_interrupt_o));

// ---- verif/asrt_top_test.sv ----
// self-checking bench for the serial block
`timescale 1ns/10ps
`include "asrt_consts.svh"
module asrt_top_test;
    localparam int BIT = 32;
    typedef struct {logic [7:0] ctrl; logic [7:0] data; logic [7:0] exp;} asrt_row_s;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] paddr_i = 32'h0000_0000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, rxd_i, txd_o, tx_interrupt_o, rx_interrupt_o;
    logic [31:0] rd;
    int n_errors = 0;
    int n_compared = 0;
    int cnt = 0;
    asrt_row_s rows[6] = '{'{8'h25, 8'hA5, 8'hA5}, '{8'h2D, 8'h3C, 8'h3C}, '{8'h3D, 8'h81, 8'h81},
        '{8'h21, 8'hD5, 8'h55}, '{8'h29, 8'hFE, 8'h7E}, '{8'h39, 8'h80, 8'h00}};
    always #4 clk_sys_i = ~clk_sys_i;
    asrt_top asrt_top_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .rxd_i(rxd_i), .txd_o(txd_o), .tx_interrupt_o(tx_interrupt_o),
        .rx_interrupt_o(rx_interrupt_o));
    asrt_station asrt_station_i (.clk_sys_i(clk_sys_i), .txd_i(txd_o), .rxd_o(rxd_i));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // read data is taken at the edge that sees pready high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        chk(32'(pslverr_o), 32'h0000_0000);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic cfg(input logic [7:0] c);
        apb(1'b1, `ASRT_CTRL_ADDR, {24'h00_0000, c});
        asrt_station_i.nbits = c[2] ? 8 : 7;
        asrt_station_i.pen = c[3];
        asrt_station_i.even = c[4];
    endtask
    task automatic wait_rx(input int n);
        for (int k = 0; k < 4000 && asrt_station_i.rx_cnt < n; k++) @(posedge clk_sys_i);
        chk(32'(asrt_station_i.rx_cnt >= n), 32'h0000_0001);
    endtask
    task automatic wait_irq();
        for (int k = 0; k < 4000 && rx_interrupt_o !== 1'b1; k++) @(posedge clk_sys_i);
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        chk(32'(txd_o), 32'h0000_0001);
        apb(1'b0, `ASRT_CTRL_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 32'h0000_00F0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // timer left in one-shot mode; enabling a direction must override it
        apb(1'b1, `ASRT_TMR_ADDR, 32'h0000_0000);
        apb(1'b1, `ASRT_DIV_ADDR, 32'h0000_0001);
        foreach (rows[i]) begin
            cfg(rows[i].ctrl);
            apb(1'b1, `ASRT_DATA_ADDR, {24'h00_0000, rows[i].data});
            cnt++;
            wait_rx(cnt);
            chk({24'h00_0000, asrt_station_i.rx_data}, {24'h00_0000, rows[i].exp});
            chk(32'(asrt_station_i.frame_ok), 32'h0000_0001);
            asrt_station_i.send(rows[i].data, 1'b0, 1'b0);
            wait_irq();
            chk(32'(rx_interrupt_o), 32'h0000_0001);
            apb(1'b0, `ASRT_DATA_ADDR, 32'h0000_0000);
            chk(rd, {24'h00_0000, rows[i].exp});
            apb(1'b0, `ASRT_CTRL_ADDR, 32'h0000_0000);
            chk(rd, {24'h00_0000, rows[i].ctrl});
            $display("row %0d done", i);
        end
        foreach (rows[i]) if (i < 2) begin
            cfg(rows[i].ctrl);
            apb(1'b1, `ASRT_DATA_ADDR, 32'h0000_0011);
            for (int k = 0; k < 4000 && tx_interrupt_o !== 1'b1; k++) @(posedge clk_sys_i);
            apb(1'b1, `ASRT_DATA_ADDR, 32'h0000_0022);
            cnt += 2;
            wait_rx(cnt);
            // eleven bits plus one idle tick between characters
            chk(asrt_station_i.gap, 11 * BIT + BIT / 16);
            chk({24'h00_0000, asrt_station_i.rx_data}, 32'h0000_0022);
        end
        $display("back to back done");
        cfg(8'h27);
        apb(1'b1, `ASRT_DATA_ADDR, 32'h0000_005A);
        repeat (BIT * 2) @(posedge clk_sys_i);
        chk(32'(tx_interrupt_o), 32'h0000_0000);
        cnt++;
        wait_rx(cnt);
        repeat (BIT * 2) @(posedge clk_sys_i);
        chk(32'(tx_interrupt_o), 32'h0000_0001);
        cfg(8'h2C);
        chk(32'(tx_interrupt_o), 32'h0000_0000);
        $display("tx irq select done");
        cfg(8'h2D);
        for (int i = 0; i < 3; i++) begin
            asrt_station_i.send(8'h33, i == 0, i == 1);
            if (i == 2) asrt_station_i.send(8'h34, 1'b0, 1'b0);
            wait_irq();
            apb(1'b0, `ASRT_DATA_ADDR, 32'h0000_0000);
            apb(1'b0, `ASRT_CTRL_ADDR, 32'h0000_0000);
            chk(rd, 32'h0000_00AD);
            apb(1'b1, `ASRT_CTRL_ADDR, 32'h0000_002D);
            apb(1'b0, `ASRT_CTRL_ADDR, 32'h0000_0000);
            chk(rd, 32'h0000_00AD);
            apb(1'b1, `ASRT_CTRL_ADDR, 32'h0000_00AD);
            apb(1'b0, `ASRT_CTRL_ADDR, 32'h0000_0000);
            chk(rd, 32'h0000_002D);
        end
        $display("error flag done");
        asrt_station_i.drive(1'b0, BIT / 4);
        asrt_station_i.drive(1'b1, BIT * 4);
        asrt_station_i.send(8'h66, 1'b0, 1'b0);
        wait_irq();
        apb(1'b0, `ASRT_DATA_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_0066);
        apb(1'b0, `ASRT_CTRL_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_002D);
        $display("false start done");
        cfg(8'h0D);
        asrt_station_i.send(8'h77, 1'b0, 1'b0);
        repeat (BIT) @(posedge clk_sys_i);
        chk(32'(rx_interrupt_o), 32'h0000_0000);
        apb(1'b1, `ASRT_DATA_ADDR, 32'h0000_0012);
        cnt++;
        wait_rx(cnt);
        chk({24'h00_0000, asrt_station_i.rx_data}, 32'h0000_0012);
        $display("rx disabled done");
        apb(1'b1, `ASRT_DATA_ADDR, 32'h0000_0000);
        repeat (BIT * 3) @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        chk(32'(txd_o), 32'h0000_0001);
        chk(32'(tx_interrupt_o), 32'h0000_0000);
        apb(1'b0, `ASRT_CTRL_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("mid-frame reset done");
        final_report();
    end
endmodule
